// ==== design/smc_pkg.sv ====
// Shared constants and types for the serializer mode control block.
package smc_pkg;
    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int WORD_W     = 20;
    localparam int FIFO_DEPTH = 16;
    localparam int FEAT_N     = 7;
    localparam int SYNC_N     = 6;
    // Bits shifted out per parallel word.
    localparam logic [4:0] BITS_WIDE   = 5'h14;
    localparam logic [4:0] BITS_NARROW = 5'h0a;
    // ****************************************
    // Register offsets and reset values
    // ****************************************
    localparam logic [3:0] OFS_DISABLE = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [6:0] DISABLE_RST = 7'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Feature bit positions
    // ****************************************
    localparam int FEAT_EDH  = 0;
    localparam int FEAT_PID  = 1;
    localparam int FEAT_ANC  = 2;
    localparam int FEAT_CRC  = 3;
    localparam int FEAT_LINE = 4;
    localparam int FEAT_TRS  = 5;
    localparam int FEAT_REMAP = 6;
    // Scrambler taps for x^9 + x^4 + 1.
    localparam int SCR_TAP_A = 8;
    localparam int SCR_TAP_B = 3;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {MODE_PASS, MODE_SCRAMBLE, MODE_ASI} smc_mode_t;
    typedef enum logic {SER_IDLE, SER_SHIFT} smc_ser_t;
endpackage

// ==== design/smc_stream_if.sv ====
// Valid/ready word stream between the block's own modules.
`timescale 1ns/1ps
interface smc_stream_if #(parameter int W = 20);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== design/smc_sync.sv ====
// Two-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps
module smc_sync #(parameter int N = 6) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [N-1:0] async,
    output logic      [N-1:0] synced
);
    typedef struct packed {
        logic [N-1:0] first;
        logic [N-1:0] second;
    } smc_sync_t;
    smc_sync_t s_q, s_d;

    // The first stage feeds only the second stage.
    always_comb begin
        s_d.first  = async;
        s_d.second = s_q.first;
    end

    // Registers both stages.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign synced = s_q.second;
endmodule

// ==== design/smc_fifo.sv ====
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module smc_fifo #(parameter int W = 20, parameter int D = 16) (
    input  wire logic clk_sys,
    input  wire logic rst,
    smc_stream_if.snk inPort,
    smc_stream_if.src outPort
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wrPtr;
        logic [AW-1:0]       rdPtr;
        logic [AW:0]         count;
    } smc_fifo_t;
    smc_fifo_t f_q, f_d;
    logic push, pop;

    // Full and empty come straight from the occupancy count.
    assign inPort.ready  = (f_q.count < (AW+1)'(D));
    assign outPort.valid = (f_q.count != '0);
    assign outPort.data  = f_q.mem[f_q.rdPtr];
    assign push = inPort.valid && inPort.ready;
    assign pop  = outPort.valid && outPort.ready;

    // Pointer and count update.
    always_comb begin
        f_d = f_q;
        if (push) begin
            f_d.mem[f_q.wrPtr] = inPort.data;
            f_d.wrPtr = f_q.wrPtr + 1'b1;
        end
        if (pop) begin
            f_d.rdPtr = f_q.rdPtr + 1'b1;
        end
        f_d.count = f_q.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Registers the FIFO state.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    fifo_no_overrun_a: assert property (@(posedge clk_sys) disable iff (rst)
        f_q.count <= (AW+1)'(D)) else $error("FIFO count above depth.");
endmodule

// ==== design/smc_serializer_ctrl.sv ====
// Mode control, feature gating and serial output for the serializer.
// Function
// - ASI mode needs ASI select high, rate select high, scramble input low.
// - ASI select low never yields ASI encoding.
// - Rate select low configures HD rates only.
// - Rate select high configures the SD rate only.
// - Width select high takes 20-bit words, low takes 10-bit words.
// - Width select is ignored in ASI mode.
// - Master enable high enables the functions allowed at the rate: six of the seven at HD, five at SD.
// - Error-detection packets SD only; line CRC and line number HD only.
// - With master high, disable register bits suppress single functions.
// - Master enable low disables every function regardless of register.
// - Scramble input high and ASI low gives scrambling mode with functions.
// - Scramble input low: no scrambling, no NRZI, no functions.
// - Output enable low turns off both serial legs.
// - Output enable high drives both serial legs.
// - Slew rate follows rate select automatically.
`timescale 1ns/1ps
module smc_serializer_ctrl
    import smc_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // Static mode pins, asynchronous.
    input  wire logic                      asiModeSelect,
    input  wire logic                      rateSelect,
    input  wire logic                      busWidthSelect,
    input  wire logic                      processingMasterEnable,
    input  wire logic                      scramblePathInput,
    input  wire logic                      serialOutEnable,
    // Parallel word input.
    input  wire logic [smc_pkg::WORD_W-1:0] pData,
    input  wire logic                      pValid,
    output logic                           pReady,
    // Serial output legs and status.
    output logic                           serialOutLegP,
    output logic                           serialOutLegPOe,
    output logic                           serialOutLegN,
    output logic                           serialOutLegNOe,
    output logic                           slewHd,
    output logic [smc_pkg::FEAT_N-1:0]     featureEnable,
    output logic [1:0]                     modeState,
    // AXI4-Lite slave.
    input  wire logic [3:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [3:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    import smc_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [FEAT_N-1:0] disable_;
        smc_ser_t          ser;
        logic [WORD_W-1:0] shift;
        logic [4:0]        bitsLeft;
        logic              scrWord;
        logic [8:0]        lfsr;
        logic              nrzi;
        logic              serBit;
        logic              awHave;
        logic [3:0]        awAddr;
        logic              wHave;
        logic [31:0]       wData;
        logic              wStrb0;
        logic              bValid;
        logic [1:0]        bResp;
        logic              rValid;
        logic [31:0]       rData;
        logic [1:0]        rResp;
    } smc_state_t;
    smc_state_t st_q, st_d;

    logic [SYNC_N-1:0] pinSync;
    logic asiS, rateS, wideS, masterS, scrS, outEnS;
    smc_mode_t mode;
    logic [FEAT_N-1:0] featRateMask;
    logic wrFire, rdFire, scrBit, rawBit;

    smc_stream_if #(.W(WORD_W)) inStream ();
    smc_stream_if #(.W(WORD_W)) outStream ();

    // ****************************************
    // Pin synchronisation and FIFO
    // ****************************************
    smc_sync #(.N(SYNC_N)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .async   ({serialOutEnable, scramblePathInput, processingMasterEnable,
                   busWidthSelect, rateSelect, asiModeSelect}),
        .synced  (pinSync)
    );
    assign {outEnS, scrS, masterS, wideS, rateS, asiS} = pinSync;

    // Incoming words queue here; pReady is the back-pressure to the source.
    assign inStream.valid = pValid;
    assign inStream.data  = pData;
    assign pReady         = inStream.ready;

    smc_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .inPort  (inStream),
        .outPort (outStream)
    );

    // ****************************************
    // Mode decode
    // ****************************************
    // Decodes the operating mode from the synchronised pins.
    function automatic smc_mode_t decodeMode(input logic asi, input logic sd,
                                            input logic scr);
        if (asi && sd && !scr) begin
            return MODE_ASI;
        end else if (scr && !asi) begin
            return MODE_SCRAMBLE;
        end else begin
            return MODE_PASS;
        end
    endfunction

    assign mode      = decodeMode(asiS, rateS, scrS);
    assign modeState = mode;

    // Functions tied to one rate are masked on the other rate.
    always_comb begin
        featRateMask = '1;
        featRateMask[FEAT_EDH]  = rateS;
        featRateMask[FEAT_CRC]  = !rateS;
        featRateMask[FEAT_LINE] = !rateS;
    end

    // Functions exist only in scrambling mode under the master enable.
    assign featureEnable = (masterS && mode == MODE_SCRAMBLE) ?
                           (featRateMask & ~st_q.disable_) : '0;

    // Slew rate picks the slow edge for SD and the fast edge for HD.
    assign slewHd = !rateS;

    // Both legs drive only while the output stage is enabled.
    assign serialOutLegPOe = outEnS;
    assign serialOutLegNOe = outEnS;
    assign serialOutLegP   = st_q.serBit;
    assign serialOutLegN   = !st_q.serBit;

    // ****************************************
    // Serializer
    // ****************************************
    assign outStream.ready = (st_q.ser == SER_IDLE);
    assign rawBit = st_q.shift[0];
    assign scrBit = rawBit ^ st_q.lfsr[SCR_TAP_A] ^ st_q.lfsr[SCR_TAP_B];

    // ****************************************
    // AXI4-Lite handshakes
    // ****************************************
    assign s_axi_awready = !st_q.awHave && !st_q.bValid;
    assign s_axi_wready  = !st_q.wHave && !st_q.bValid;
    assign s_axi_bvalid  = st_q.bValid;
    assign s_axi_bresp   = st_q.bResp;
    assign s_axi_arready = !st_q.rValid;
    assign s_axi_rvalid  = st_q.rValid;
    assign s_axi_rdata   = st_q.rData;
    assign s_axi_rresp   = st_q.rResp;
    assign wrFire = st_q.awHave && st_q.wHave && !st_q.bValid;
    assign rdFire = s_axi_arvalid && s_axi_arready;

    // Next-state logic for serializer and register bus.
    always_comb begin
        st_d = st_q;
        case (st_q.ser)
            SER_IDLE: begin
                if (outStream.valid) begin
                    st_d.ser = SER_SHIFT;
                    st_d.shift = outStream.data;
                    st_d.scrWord = (mode == MODE_SCRAMBLE);
                    if (mode == MODE_ASI || !wideS) begin
                        st_d.bitsLeft = BITS_NARROW;
                    end else begin
                        st_d.bitsLeft = BITS_WIDE;
                    end
                end
            end
            SER_SHIFT: begin
                st_d.shift = {1'b0, st_q.shift[WORD_W-1:1]};
                st_d.bitsLeft = st_q.bitsLeft - 5'h01;
                if (st_q.scrWord) begin
                    st_d.lfsr = {st_q.lfsr[7:0], scrBit};
                    st_d.nrzi = st_q.nrzi ^ scrBit;
                    st_d.serBit = st_q.nrzi ^ scrBit;
                end else begin
                    st_d.serBit = rawBit;
                end
                if (st_q.bitsLeft == 5'h01) begin
                    st_d.ser = SER_IDLE;
                end
            end
            default: begin
                st_d.ser = SER_IDLE;
            end
        endcase
        // Write address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.awHave = 1'b1;
            st_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.wHave = 1'b1;
            st_d.wData = s_axi_wdata;
            st_d.wStrb0 = s_axi_wstrb[0];
        end
        if (wrFire) begin
            st_d.awHave = 1'b0;
            st_d.wHave = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp = RESP_OKAY;
            if (st_q.awAddr == OFS_DISABLE) begin
                if (st_q.wStrb0) begin
                    st_d.disable_ = st_q.wData[FEAT_N-1:0];
                end
            end else if (st_q.awAddr != OFS_STATUS) begin
                st_d.bResp = RESP_SLVERR;
            end
        end
        if (st_q.bValid && s_axi_bready) begin
            st_d.bValid = 1'b0;
        end
        // Reads return the disable register or the live status.
        if (rdFire) begin
            st_d.rValid = 1'b1;
            st_d.rResp = RESP_OKAY;
            st_d.rData = '0;
            case (s_axi_araddr)
                OFS_DISABLE: begin
                    st_d.rData[FEAT_N-1:0] = st_q.disable_;
                end
                OFS_STATUS: begin
                    st_d.rData = {15'h0000, featureEnable, 3'h0, outEnS, wideS,
                                  rateS, 2'h0, mode};
                end
                default: begin
                    st_d.rResp = RESP_SLVERR;
                end
            endcase
        end else if (st_q.rValid && s_axi_rready) begin
            st_d.rValid = 1'b0;
        end
    end

    // Registers all state.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
            st_q.disable_ <= DISABLE_RST;
            st_q.ser <= SER_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // ASI needs its full pin set.
    asi_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
        (mode == MODE_ASI) |-> (asiS && rateS && !scrS))
        else $error("ASI mode without its pin combination.");

    // ASI select low keeps ASI off.
    no_asi_a: assert property (@(posedge clk_sys) disable iff (rst)
        !asiS |-> (mode != MODE_ASI))
        else $error("ASI mode with select low.");

    // Master low clears all features.
    master_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        !masterS |-> (featureEnable == '0))
        else $error("Feature on, master low.");

    // Rate-bound features stay off.
    rate_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rateS ? (featureEnable[FEAT_CRC] || featureEnable[FEAT_LINE])
               : featureEnable[FEAT_EDH]) == 1'b0)
        else $error("Feature active on the wrong rate.");

    // A set disable bit wins.
    disable_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
        (featureEnable & st_q.disable_) == '0)
        else $error("Disabled feature on.");

    // No scrambling, no features.
    no_scramble_a: assert property (@(posedge clk_sys) disable iff (rst)
        !scrS |-> (featureEnable == '0 && mode != MODE_SCRAMBLE))
        else $error("Scrambling with scramble input low.");

    // Master high enables the set.
    full_feat_a: assert property (@(posedge clk_sys) disable iff (rst)
        (masterS && scrS && !asiS && st_q.disable_ == '0) |->
        featureEnable == featRateMask) else $error("Feature missing.");

    // ASI words are 10 bits.
    width_asi_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.ser == SER_IDLE && outStream.valid && mode == MODE_ASI) |=>
        st_q.bitsLeft == BITS_NARROW) else $error("ASI word not 10 bits.");

    // Width high loads 20 bits.
    width_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.ser == SER_IDLE && outStream.valid && mode != MODE_ASI && wideS) |=>
        st_q.bitsLeft == BITS_WIDE) else $error("Wide word not 20 bits.");

    // Enable low releases both legs.
    legs_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
        !outEnS |-> !serialOutLegPOe && !serialOutLegNOe)
        else $error("Legs driven with output disabled.");

    // Enable high drives a pair.
    legs_on_a: assert property (@(posedge clk_sys) disable iff (rst)
        outEnS |-> serialOutLegPOe && serialOutLegNOe &&
        serialOutLegN != serialOutLegP)
        else $error("Legs not driven differentially.");

    // Slew follows the rate pin.
    slew_rate_a: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(rateS) |-> $changed(slewHd))
        else $error("Slew did not follow rate.");

    // Raw words leave unaltered.
    pass_raw_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.ser == SER_SHIFT && !st_q.scrWord) |=> serialOutLegP == $past(rawBit))
        else $error("Pass-through bit altered.");

    // Responses stand until taken.
    bvalid_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("Write response dropped early.");

    rvalid_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("Read data dropped early.");
endmodule

// ==== testbench/smc_board_model.sv ====
// Board-side model: static mode pin levels and a parallel word source.
`timescale 1ns/1ps
module smc_board_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [5:0]  pinCfg,
    input  wire logic        pReady,
    output logic             asiModeSelect,
    output logic             rateSelect,
    output logic             busWidthSelect,
    output logic             processingMasterEnable,
    output logic             scramblePathInput,
    output logic             serialOutEnable,
    output logic [19:0]      pData,
    output logic             pValid
);
    logic [19:0] wordQ[$];
    int          taken;
    // Pins are plain levels; while trimming the bench also drives the master enable low (6'h32).
    assign {serialOutEnable, scramblePathInput, processingMasterEnable} = pinCfg[5:3];
    assign {busWidthSelect, rateSelect, asiModeSelect} = pinCfg[2:0];
    initial begin
        pValid = 1'b0;
        pData = 20'h00000;
        taken = 0;
    end
    // Words go out back to back; a word is held until taken, then the next queued word follows or, with none left, the bus shows its inverse.
    always @(posedge clk_sys) begin
        if (rst) begin
            pValid <= 1'b0;
        end else if (!pValid || pReady) begin
            if (pValid) taken <= taken + 1;
            if (wordQ.size() > 0) begin
                pValid <= 1'b1;
                pData <= wordQ.pop_front();
            end else begin
                pValid <= 1'b0;
                pData <= ~pData;
            end
        end
    end
endmodule

// ==== testbench/smc_serializer_ctrl_tb.sv ====
// Self-checking bench for the serializer mode control block.
`timescale 1ns/1ps
module smc_serializer_ctrl_tb;
    import smc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [5:0] pinCfg = 6'h00;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic asiModeSelect, rateSelect, busWidthSelect, processingMasterEnable;
    logic scramblePathInput, serialOutEnable, pValid, pReady, slewHd;
    logic serialOutLegP, serialOutLegPOe, serialOutLegN, serialOutLegNOe;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, modeState;
    logic [31:0] s_axi_rdata;
    logic [WORD_W-1:0] pData;
    logic [FEAT_N-1:0] featureEnable;
    int failCount = 0;
    int checkCount = 0;
    // ****
    // Harness
    // ****
    smc_board_model board_u (.clk_sys, .rst, .pinCfg, .pReady, .asiModeSelect, .rateSelect,
        .busWidthSelect, .processingMasterEnable, .scramblePathInput, .serialOutEnable,
        .pData, .pValid);
    smc_serializer_ctrl dut_u (.clk_sys, .rst, .asiModeSelect, .rateSelect, .busWidthSelect,
        .processingMasterEnable, .scramblePathInput, .serialOutEnable, .pData, .pValid,
        .pReady, .serialOutLegP, .serialOutLegPOe, .serialOutLegN, .serialOutLegNOe, .slewHd,
        .featureEnable, .modeState, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // The clock toggles every half period of 5 ns.
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic giveVerdict();
        $display("Checks made %0d, mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checkCount++;
        if (g !== e) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang();
        failCount++;
        $display("MISMATCH handshake expected answer seen timeout");
        giveVerdict();
    endtask
    // ****
    // Bus cycles
    // ****
    // Both write halves are offered together and each is released once taken.
    task automatic wrChk(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 60);
        if (n >= 60) hang();
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 60);
        if (n >= 60) hang();
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask
    // Expected feature enables and mode for a pin setting and a disable mask.
    function automatic logic [8:0] expMode(input logic [5:0] c, input logic [6:0] d);
        logic [1:0] m;
        logic [6:0] f;
        m = (c[4] && !c[0]) ? 2'h1 : ((c[0] && c[1] && !c[4]) ? 2'h2 : 2'h0);
        f = (m == 2'h1 && c[3]) ? ~d : 7'h00;
        f = c[1] ? (f & 7'h67) : (f & 7'h7e);
        return {f, m};
    endfunction
    // Sets pins, lets them cross the synchronisers and checks every static output.
    task automatic pins(input logic [5:0] c, input logic [6:0] d);
        logic [8:0] e;
        e = expMode(c, d);
        @(posedge clk_sys);
        pinCfg <= c;
        ticks(6);
        chk("modeState", 32'(e[1:0]), 32'(modeState));
        chk("featureEnable", 32'(e[8:2]), 32'(featureEnable));
        chk("slewHd", 32'(!c[1]), 32'(slewHd));
        chk("legOe", 32'({c[5], c[5]}), 32'({serialOutLegPOe, serialOutLegNOe}));
        chk("legPair", 32'h1, 32'(serialOutLegP ^ serialOutLegN));
    endtask
    // ****
    // Scenarios
    // ****
    task automatic tReset();
        chk("resetState", 32'h00000002, 32'({featureEnable, modeState, serialOutLegPOe,
            serialOutLegNOe, serialOutLegP, serialOutLegN, !pReady}));
        rdChk(OFS_DISABLE, 32'h00000000, RESP_OKAY);
    endtask
    task automatic tModes();
        for (int i = 0; i < 64; i++) pins(6'(i), 7'h00);
    endtask
    task automatic tDisable();
        logic [8:0] e;
        e = expMode(6'h3a, 7'h05);
        wrChk(OFS_DISABLE, 32'h00000005, 4'h1, RESP_OKAY);
        pins(6'h3a, 7'h05);
        rdChk(OFS_STATUS, 32'({e[8:2], 3'h0, 3'h5, 2'h0, e[1:0]}), RESP_OKAY);
        pins(6'h38, 7'h05);
        pins(6'h32, 7'h05);
        wrChk(OFS_DISABLE, 32'h0000007f, 4'h0, RESP_OKAY);
        wrChk(OFS_STATUS, 32'h0000007f, 4'hf, RESP_OKAY);
        rdChk(OFS_DISABLE, 32'h00000005, RESP_OKAY);
        rdChk(4'h8, 32'h00000000, RESP_SLVERR);
        wrChk(4'hc, 32'h00000001, 4'hf, RESP_SLVERR);
        wrChk(OFS_DISABLE, 32'h00000000, 4'hf, RESP_OKAY);
    endtask
    // Two words go out LSB first, n bits each; the load cycle repeats the first's last bit.
    task automatic sendPair(input logic [5:0] c, input int n);
        logic [19:0] w0, w1;
        logic [39:0] e;
        logic [99:0] rec;
        bit found, ok;
        w0 = 20'h5a3c6;
        w1 = 20'h93e1b;
        e = (n == 20) ? {w1, w0} : {20'h00000, w1[9:0], w0[9:0]};
        found = 0;
        pins(c, 7'h00);
        @(negedge clk_sys);
        board_u.wordQ.push_back(w0);
        board_u.wordQ.push_back(w1);
        for (int k = 0; k < 100; k++) begin
            @(posedge clk_sys);
            #1 rec[k] = serialOutLegP;
        end
        for (int o = 0; o < 40; o++) begin
            ok = 1;
            for (int b = 0; b < 2 * n; b++) if (rec[o + b + int'(b >= n)] !== e[b]) ok = 0;
            if (ok) found = 1;
        end
        chk("serialBits", 32'h1, 32'(found));
    endtask
    task automatic tSerial();
        sendPair(6'h24, 20);
        sendPair(6'h20, 10);
        sendPair(6'h27, 10);
    endtask
    // The FIFO refuses after sixteen words and drains once the source stops.
    task automatic tFill();
        int n;
        pins(6'h24, 7'h00);
        @(negedge clk_sys);
        n = board_u.taken;
        for (int k = 0; k < 24; k++) board_u.wordQ.push_back(20'(k * 37));
        for (int k = 0; k < 60 && pReady !== 1'b0; k++) @(negedge clk_sys);
        chk("fifoFull", 32'h1, 32'(board_u.taken - n >= 16 && board_u.taken - n <= 18));
        for (int k = 0; k < 900 && board_u.taken - n < 24; k++) @(posedge clk_sys);
        ticks(420);
        chk("fifoDrained", 32'h1, 32'(pReady));
        chk("wordsTaken", 32'd24, 32'(board_u.taken - n));
    endtask
    // Reset for 16 cycles, then every scenario in turn.
    initial begin
        ticks(16);
        rst <= 1'b0;
        tReset();
        tModes();
        tDisable();
        tSerial();
        tFill();
        giveVerdict();
    end
endmodule
